// >>> hdl/infrared_uart_tx_codec.sv
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "irsci_params.svh"
// Contract
// - With infrared off, serial data passes between pins and core unchanged.
// - Core makes 16x and 32x ticks; only 32x times pulses, only 16x receives.
// - Each zero bit gives one short low pulse; one bits stay high.
// - Pulse width is 1/32, 1/16 or 3/16 bit, chosen by software.
// - Pulses of back to back zeros start exactly one bit apart.
// - Decoder 4-bit counter on 16x tick; a pulse starts it, output low.
// - Pulses ignored at count 0..7; above 7 a pulse restarts the count.
// - At count 15 output goes high, counter halts; late jitter ignored.
// - baud_source_select picks bus clock or crystal_ref_clk for baud.
// - char_length_select gives 8 or 9 data bits; tx_ninth_bit is bit 8.
// - A transmission begins with a one-character idle preamble.
// - Shift register frames data with zero start and one stop, LSB first.
// - Empty flag sets on transfer to shifter; request when enabled.
// - Line idles high; clearing unit_on releases the pins at once.
// - While send_break_bit is set, all-zero break characters repeat.
// - After break ends, at least one high bit precedes the next start.
// - Break is a start bit, zero data bits and a zero stop position.
// - Break sets stop error, rx full, break seen; clears data, ninth bit.
// - tx_on cleared idles after current char; off-on queues an idle char.
module infrared_uart_tx_codec
	import irsci_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        crystal_ref_clk,
	input  wire logic        rx_port_pin,
	output logic             tx_port_pin_o,
	output logic             tx_port_pin_oe,
	output logic             tx_irq_req
);
	// Control and status state
	logic        unit_on_q, char9_q, ir_on_q, baud_src_q;
	logic        tx_on_q, break_q, tirq_on_q;
	logic [1:0]  pw_sel_q;
	logic        tx_ninth_q, rx_ninth_q;
	logic        tbe_q, tbe_armed_q, rx_full_q, stop_err_q, break_seen_q;
	logic [7:0]  tx_buf_q, rx_buf_q, baud_div_q;
	logic [31:0] prdata_q;
	logic        pready_q, pslverr_q, irq_q, pin_oe_q, tx_busy;

	logic        acc, wr, rd;
	logic [31:0] rdata_d;
	logic        map_hit;

	assign acc = psel & penable & pready_q;
	assign wr  = acc & pwrite;
	assign rd  = acc & ~pwrite;

	// Read mux, sampled in the setup cycle
	always_comb begin
		rdata_d = 32'h0;
		map_hit = 1'b1;
		unique case (paddr)
			`OFF_CTRL1: rdata_d = {28'h0, baud_src_q, ir_on_q, char9_q, unit_on_q};
			`OFF_CTRL2: rdata_d = {27'h0, pw_sel_q, tirq_on_q, break_q, tx_on_q};
			`OFF_CTRL3: rdata_d = {30'h0, rx_ninth_q, tx_ninth_q};
			`OFF_STAT1: rdata_d = {28'h0, tx_busy, stop_err_q, rx_full_q, tbe_q};
			`OFF_STAT2: rdata_d = {31'h0, break_seen_q};
			`OFF_DATA:  rdata_d = {24'h0, rx_buf_q};
			`OFF_BAUD:  rdata_d = {24'h0, baud_div_q};
			default:    map_hit = 1'b0;
		endcase
	end

	// Zero-wait slave: ready one cycle after setup
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0;
		end else begin
			pready_q  <= psel & ~penable;
			pslverr_q <= psel & ~penable & ~map_hit;
			if (psel & ~penable & ~pwrite)
				prdata_q <= rdata_d;
		end
	end

	// Control register writes
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			unit_on_q  <= 1'b0;
			char9_q    <= 1'b0;
			ir_on_q    <= 1'b0;
			baud_src_q <= 1'b0;
			tx_on_q    <= 1'b0;
			break_q    <= 1'b0;
			tirq_on_q  <= 1'b0;
			pw_sel_q   <= 2'h0;
			tx_ninth_q <= 1'b0;
			baud_div_q <= 8'h0;
		end else if (wr) begin
			unique case (paddr)
				`OFF_CTRL1: begin
					unit_on_q  <= pwdata[`B_UNIT_ON];
					char9_q    <= pwdata[`B_CHAR9];
					ir_on_q    <= pwdata[`B_IR_ON];
					baud_src_q <= pwdata[`B_BAUD_SRC];
				end
				`OFF_CTRL2: begin
					tx_on_q   <= pwdata[`B_TX_ON];
					break_q   <= pwdata[`B_BREAK];
					tirq_on_q <= pwdata[`B_TIRQ_ON];
					pw_sel_q  <= pwdata[`B_PW_LO+1:`B_PW_LO];
				end
				`OFF_CTRL3: tx_ninth_q <= pwdata[`B_TX_NINTH];
				`OFF_BAUD:  baud_div_q <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Baud source: crystal input synchronised before edge detection
	logic [2:0] xtal_q;
	logic       src_tick;
	logic [7:0] div_cnt_q;
	logic       x32_tick, x16_ph_q, x16_tick;
	logic [3:0] bit_ph_q;
	logic       bit_tick;

	always_ff @(posedge clock) begin
		if (!rst_n)
			xtal_q <= 3'h0;
		else
			xtal_q <= {xtal_q[1:0], crystal_ref_clk};
	end

	assign src_tick = baud_src_q ? (xtal_q[1] & ~xtal_q[2]) : 1'b1;
	assign x32_tick = src_tick & (div_cnt_q == baud_div_q);
	assign x16_tick = x32_tick & x16_ph_q;
	assign bit_tick = x16_tick & (bit_ph_q == `X16_PER_BIT);

	// Reference tick chain; halted while the unit is off
	always_ff @(posedge clock) begin
		if (!rst_n || !unit_on_q) begin
			div_cnt_q <= 8'h0;
			x16_ph_q  <= 1'b0;
			bit_ph_q  <= 4'h0;
		end else if (src_tick) begin
			div_cnt_q <= x32_tick ? 8'h0 : div_cnt_q + 8'h1;
			if (x32_tick)
				x16_ph_q <= ~x16_ph_q;
			if (x16_tick)
				bit_ph_q <= bit_ph_q + 4'h1;
		end
	end

	// Transmitter
	tx_state_e  tx_st_q;
	logic [10:0] sh_q;
	logic [3:0]  left_q, frame_len;
	logic        tx_prev_q, tx_gap_q, q_idle_q, pre_due_q, tx_serial;

	assign frame_len = char9_q ? `LEN_CHAR9 : `LEN_CHAR8;
	assign tx_busy   = (tx_st_q != TX_IDLE);
	assign tx_serial = tx_busy ? sh_q[0] : 1'b1;

	// Off-then-on of tx_on during a frame queues one idle char
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tx_prev_q <= 1'b0;
			tx_gap_q  <= 1'b0;
			q_idle_q  <= 1'b0;
			pre_due_q <= 1'b1;
		end else begin
			tx_prev_q <= tx_on_q;
			if (!tx_busy) begin
				tx_gap_q <= 1'b0;
				q_idle_q <= 1'b0;
				// Any idle time with tx_on low owes a preamble at the next start
				pre_due_q <= !tx_on_q || (pre_due_q && !bit_tick);
			end else begin
				if (tx_prev_q & ~tx_on_q)
					tx_gap_q <= 1'b1;
				if (tx_gap_q & tx_on_q & ~tx_prev_q)
					q_idle_q <= 1'b1;
				if (bit_tick && left_q == 4'h1) begin
					tx_gap_q <= 1'b0;
					q_idle_q <= 1'b0;
				end
			end
		end
	end

	// Frame sequencer; all loads happen on a bit boundary
	always_ff @(posedge clock) begin
		if (!rst_n || !unit_on_q) begin
			tx_st_q <= TX_IDLE;
			sh_q    <= 11'h7ff;
			left_q  <= 4'h0;
		end else if (bit_tick) begin
			if (tx_busy && left_q != 4'h1) begin
				sh_q   <= {1'b1, sh_q[10:1]};
				left_q <= left_q - 4'h1;
			end else if (tx_st_q == TX_BREAK && !break_q) begin
				tx_st_q <= TX_MARK;
				sh_q    <= 11'h7ff;
				left_q  <= 4'h1;
			end else if (!tx_on_q) begin
				tx_st_q <= TX_IDLE;
			end else if (q_idle_q) begin
				tx_st_q <= TX_QIDLE;
				sh_q    <= 11'h7ff;
				left_q  <= frame_len;
			end else if (!tx_busy && pre_due_q) begin
				tx_st_q <= TX_PREAMBLE;
				sh_q    <= 11'h7ff;
				left_q  <= frame_len;
			end else if (break_q) begin
				tx_st_q <= TX_BREAK;
				sh_q    <= 11'h0;
				left_q  <= frame_len;
			end else if (!tbe_q) begin
				tx_st_q <= TX_DATA;
				sh_q    <= {1'b1, char9_q ? tx_ninth_q : 1'b1, tx_buf_q, 1'b0};
				left_q  <= frame_len;
			end else begin
				tx_st_q <= TX_IDLE;
			end
		end
	end

	// Transfer into the shifter frees the buffer
	logic load_data;
	assign load_data = bit_tick & tx_on_q & ~tbe_q & ~break_q & ~q_idle_q
		& (tx_busy ? (left_q == 4'h1 && tx_st_q != TX_BREAK) : ~pre_due_q);

	// Empty flag: status read arms, data write clears, set wins
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tbe_q       <= 1'b1;
			tbe_armed_q <= 1'b0;
			tx_buf_q    <= 8'h0;
		end else begin
			if (rd && paddr == `OFF_STAT1 && tbe_q)
				tbe_armed_q <= 1'b1;
			if (wr && paddr == `OFF_DATA) begin
				tx_buf_q    <= pwdata[7:0];
				tbe_armed_q <= 1'b0;
				if (tbe_armed_q)
					tbe_q <= 1'b0;
			end
			if (load_data)
				tbe_q <= 1'b1;
		end
	end

	// Transmit request level, registered
	always_ff @(posedge clock) begin
		if (!rst_n)
			irq_q <= 1'b0;
		else
			irq_q <= tbe_q & tirq_on_q & unit_on_q;
	end

	// Infrared encoder: pulse starts one cycle after the boundary of each zero bit
	logic       bit_start_q;
	logic [2:0] pulse_left_q;
	logic       pw_tick, enc_out, line;

	assign pw_tick = x32_tick; // Whole 32x periods avoid a short first 16x tick
	assign enc_out = (pulse_left_q == 3'h0);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bit_start_q  <= 1'b0;
			pulse_left_q <= 3'h0;
		end else begin
			bit_start_q <= bit_tick;
			if (bit_start_q && !tx_serial) begin
				// Same anchor each bit keeps zero pulses one bit apart
				pulse_left_q <= (pw_sel_q == PW_3_16) ? 3'h6 : (pw_sel_q == PW_1_32) ? 3'h1 : 3'h2;
			end else if (pw_tick && pulse_left_q != 3'h0) begin
				pulse_left_q <= pulse_left_q - 3'h1;
			end
		end
	end

	assign line = ir_on_q ? enc_out : tx_serial;

	// Open-drain pin: drive low only, release entirely when unit is off
	always_ff @(posedge clock) begin
		if (!rst_n)
			pin_oe_q <= 1'b0;
		else
			pin_oe_q <= unit_on_q & ~line;
	end

	// Receive pin synchroniser
	logic [1:0] rx_sync_q;
	logic       rx_prev_q, rx_fall;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rx_sync_q <= 2'h3;
			rx_prev_q <= 1'b1;
		end else begin
			rx_sync_q <= {rx_sync_q[0], rx_port_pin};
			rx_prev_q <= rx_sync_q[1];
		end
	end

	assign rx_fall = rx_prev_q & ~rx_sync_q[1];

	// Infrared decoder: stretches narrow pulses to full zero bits
	logic [3:0] dec_cnt_q;
	logic       dec_run_q, dec_out_q, jitter_q;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			dec_cnt_q <= 4'h0;
			dec_run_q <= 1'b0;
			dec_out_q <= 1'b1;
			jitter_q  <= 1'b0;
		end else if (!dec_run_q) begin
			if (x16_tick)
				jitter_q <= 1'b0;
			if (rx_fall && !jitter_q) begin
				dec_run_q <= 1'b1;
				dec_cnt_q <= 4'h0;
				dec_out_q <= 1'b0;
			end
		end else if (rx_fall && dec_cnt_q > `DEC_HALF) begin
			dec_cnt_q <= 4'h0;
		end else if (x16_tick) begin
			if (dec_cnt_q == `DEC_LAST) begin
				dec_run_q <= 1'b0;
				dec_out_q <= 1'b1;
				jitter_q  <= 1'b1;
			end else begin
				dec_cnt_q <= dec_cnt_q + 4'h1;
			end
		end
	end

	// Core receive line: decoded or raw, per infrared enable
	logic rx_line, rx_line_prev_q;
	assign rx_line = ir_on_q ? dec_out_q : rx_sync_q[1];

	// Minimal receiver, mid-bit sampling on the 16x tick
	rx_state_e  rx_st_q;
	logic [3:0] rx_ph_q, rx_idx_q;
	logic [9:0] rx_sh_q;
	logic       rx_done, rx_brk, rx_stop;

	assign rx_stop = rx_line;
	assign rx_done = (rx_st_q == RX_BITS) & x16_tick & (rx_ph_q == `RX_SAMPLE)
		& (rx_idx_q == frame_len - 4'h1);
	assign rx_brk  = rx_done & ~rx_stop & (rx_sh_q[9:2] == 8'h0) & ~(char9_q & rx_sh_q[1]);

	always_ff @(posedge clock) begin
		if (!rst_n || !unit_on_q) begin
			rx_st_q        <= RX_IDLE;
			rx_ph_q        <= 4'h0;
			rx_idx_q       <= 4'h0;
			rx_sh_q        <= 10'h0;
			rx_line_prev_q <= 1'b1;
		end else begin
			rx_line_prev_q <= rx_line;
			if (rx_st_q == RX_IDLE) begin
				if (rx_line_prev_q & ~rx_line) begin
					rx_st_q  <= RX_BITS;
					rx_ph_q  <= 4'h0;
					rx_idx_q <= 4'h0;
				end
			end else if (x16_tick) begin
				rx_ph_q <= rx_ph_q + 4'h1;
				if (rx_ph_q == `RX_SAMPLE) begin
					rx_idx_q <= rx_idx_q + 4'h1;
					if (rx_idx_q != 4'h0)
						rx_sh_q <= {rx_line, rx_sh_q[9:1]};
					if (rx_done)
						rx_st_q <= RX_IDLE;
				end
			end
		end
	end

	// Receive flags; reading data clears them, set wins
	logic [8:0] rx_word;
	assign rx_word = char9_q ? rx_sh_q[9:1] : {rx_sh_q[9], rx_sh_q[9:2]};

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rx_full_q    <= 1'b0;
			stop_err_q   <= 1'b0;
			break_seen_q <= 1'b0;
			rx_buf_q     <= 8'h0;
			rx_ninth_q   <= 1'b0;
		end else begin
			if (rd && paddr == `OFF_DATA) begin
				rx_full_q    <= 1'b0;
				stop_err_q   <= 1'b0;
				break_seen_q <= 1'b0;
			end
			if (rx_done) begin
				rx_full_q  <= 1'b1;
				stop_err_q <= ~rx_stop;
				rx_buf_q   <= rx_brk ? 8'h0 : rx_word[7:0];
				rx_ninth_q <= rx_brk ? 1'b0 : rx_word[8];
				if (rx_brk)
					break_seen_q <= 1'b1;
			end
		end
	end

	// Registered outputs; transmit pin data tied low
	assign prdata         = prdata_q;
	assign pready         = pready_q;
	assign pslverr        = pslverr_q;
	assign tx_port_pin_o  = 1'b0;
	assign tx_port_pin_oe = pin_oe_q;
	assign tx_irq_req     = irq_q;

endmodule // infrared_uart_tx_codec

// >>> hdl/irsci_params.svh
`ifndef IRSCI_PARAMS_SVH
`define IRSCI_PARAMS_SVH

// Register byte offsets
`define OFF_CTRL1 8'h00
`define OFF_CTRL2 8'h04
`define OFF_CTRL3 8'h08
`define OFF_STAT1 8'h0c
`define OFF_STAT2 8'h10
`define OFF_DATA  8'h14
`define OFF_BAUD  8'h18

// Control register one fields
`define B_UNIT_ON   0
`define B_CHAR9     1
`define B_IR_ON     2
`define B_BAUD_SRC  3
// Control register two fields
`define B_TX_ON     0
`define B_BREAK     1
`define B_TIRQ_ON   2
`define B_PW_LO     3
// Control register three fields
`define B_TX_NINTH  0
`define B_RX_NINTH  1
// Status register one fields
`define B_TBE       0
`define B_RX_FULL   1
`define B_STOP_ERR  2
`define B_TX_BUSY   3
// Status register two fields
`define B_BREAK_SEEN 0

// Timing counts in 16x ticks; frame lengths in bits
`define X16_PER_BIT   4'hf
`define DEC_HALF      4'h7
`define DEC_LAST      4'hf
`define RX_SAMPLE     4'h8
`define LEN_CHAR8     4'ha
`define LEN_CHAR9     4'hb

`endif

// >>> hdl/irsci_pkg.sv
package irsci_pkg;
	typedef enum logic [2:0] {
		TX_IDLE,
		TX_PREAMBLE,
		TX_DATA,
		TX_BREAK,
		TX_MARK,
		TX_QIDLE
	} tx_state_e;

	typedef enum logic {
		RX_IDLE,
		RX_BITS
	} rx_state_e;

	typedef enum logic [1:0] {
		PW_3_16,
		PW_1_16,
		PW_1_32,
		PW_RSVD
	} pulse_width_e;
endpackage

// >>> sim/remote_serial_model.sv
`timescale 1ns/100ps
module remote_serial_model #(
	parameter int BIT_CYC = 32
) (
	input  wire logic clock,
	input  wire logic line_in,
	output logic      line_out
);
	// Far end idles at mark
	initial line_out = 1'h1;

	// Sends n bits LSB first; infrared zeros shrink to 3/16-bit pulses
	task automatic send_bits(input logic [10:0] bits, input int n, input bit ir);
		for (int i = 0; i < n; i++) begin
			for (int c = 0; c < BIT_CYC; c++) begin
				@(posedge clock);
				line_out <= (ir && c >= BIT_CYC * 3 / 16) ? 1'h1 : bits[i];
			end
		end
		@(posedge clock);
		line_out <= 1'h1;
	endtask

	// Finds a start bit, samples mid-bit; returns cycles spent waiting
	task automatic get_bits(input int n, output logic [10:0] bits, output int wait_cyc);
		bits = 11'h000;
		wait_cyc = 0;
		while (line_in !== 1'h0 && wait_cyc < 4000) begin
			@(negedge clock);
			wait_cyc++;
		end
		repeat (BIT_CYC / 2) @(negedge clock);
		for (int i = 0; i < n; i++) begin
			if (i > 0)
				repeat (BIT_CYC) @(negedge clock);
			bits[i] = line_in;
		end
	endtask
endmodule // remote_serial_model

// >>> sim/infrared_uart_tx_codec_monitor.sv
`timescale 1ns/100ps
`include "irsci_params.svh"
module infrared_uart_tx_codec_monitor #(
	parameter int BIT_CYC = 32
) (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        crystal_ref_clk,
	input wire logic        rx_port_pin,
	input wire logic        tx_port_pin_o,
	input wire logic        tx_port_pin_oe,
	input wire logic        tx_irq_req
);
	logic        wr_ok;
	logic [4:0]  ctl1_q;
	logic [4:0]  ctl2_q;
	logic [11:0] low_q;
	logic [11:0] gap_q;
	logic [11:0] pw_len;

	default clocking mon_clk @(posedge clock); endclocking
	default disable iff (!rst_n);

	// Shadow control words, taken at the completing edge
	assign wr_ok = psel && penable && pready && pwrite && !pslverr;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctl1_q <= 5'h00;
			ctl2_q <= 5'h00;
		end else if (wr_ok && paddr == `OFF_CTRL1)
			ctl1_q <= pwdata[4:0];
		else if (wr_ok && paddr == `OFF_CTRL2)
			ctl2_q <= pwdata[4:0];
	end
	// Low stretch length; saturates so long breaks stay harmless
	always_ff @(posedge clock) begin
		if (!rst_n || !tx_port_pin_oe)
			low_q <= 12'h000;
		else if (low_q != 12'hfff)
			low_q <= low_q + 12'h001;
	end
	// Cycles since the last pulse start
	always_ff @(posedge clock) begin
		if (!rst_n)
			gap_q <= 12'hfff;
		else if ($rose(tx_port_pin_oe))
			gap_q <= 12'h001;
		else if (gap_q != 12'hfff)
			gap_q <= gap_q + 12'h001;
	end
	// Pulse length in cycles; only valid with the divisor at zero
	always_comb begin
		case (ctl2_q[4:3])
			2'h0: pw_len = 12'h006;
			2'h2: pw_len = 12'h001;
			default: pw_len = 12'h002;
		endcase
	end

	AST_OPEN_DRAIN: assert property (tx_port_pin_o == 1'h0)
		else $error("tx pin data not low");
	AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	AST_PREADY_CAUSE: assert property (pready |-> $past(psel && !penable))
		else $error("ready without setup");
	AST_SLVERR_MAP: assert property (pready |-> pslverr == (paddr > `OFF_BAUD || paddr[1:0] != 2'h0))
		else $error("slave error does not match address");
	AST_RESET_IDLE: assert property ($rose(rst_n) |-> !tx_port_pin_oe && !tx_irq_req)
		else $error("outputs active after reset");
	AST_UNIT_OFF: assert property (!ctl1_q[0] && !$past(ctl1_q[0]) |-> !tx_port_pin_oe)
		else $error("pin driven with unit off");
	AST_IRQ_MASK: assert property (!(ctl1_q[0] && ctl2_q[2]) && !$past(ctl1_q[0] && ctl2_q[2])
		|-> !tx_irq_req)
		else $error("request while masked");
	AST_IR_WIDTH: assert property (ctl1_q[0] && ctl1_q[2] && $fell(tx_port_pin_oe)
		|-> low_q == pw_len)
		else $error("infrared pulse width wrong");
	AST_NRZ_BITS: assert property (ctl1_q[0] && !ctl1_q[2] && $fell(tx_port_pin_oe)
		&& low_q != 12'hfff |-> low_q % BIT_CYC == 0)
		else $error("low stretch not whole bits");
	AST_IR_SPACING: assert property (ctl1_q[2] && $rose(tx_port_pin_oe) && gap_q < 12'd300
		|-> gap_q % BIT_CYC == 0)
		else $error("pulse spacing not whole bits");
endmodule // infrared_uart_tx_codec_monitor

// >>> sim/infrared_uart_tx_codec_test.sv
`timescale 1ns/100ps
`include "irsci_params.svh"
module infrared_uart_tx_codec_test;
	logic        clock, rst_n, psel, penable, pwrite, crystal_ref_clk, rx_port_pin;
	logic        pready, pslverr, tx_port_pin_o, tx_port_pin_oe, tx_irq_req, tx_level, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic [10:0] b;
	int          n_mismatch, checks, w, n;

	// Pull-up on the open-drain transmit pin
	assign tx_level = tx_port_pin_oe ? tx_port_pin_o : 1'h1;

	infrared_uart_tx_codec uut (
		.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.crystal_ref_clk(crystal_ref_clk), .rx_port_pin(rx_port_pin),
		.tx_port_pin_o(tx_port_pin_o), .tx_port_pin_oe(tx_port_pin_oe), .tx_irq_req(tx_irq_req)
	);
	remote_serial_model ptn (.clock(clock), .line_in(tx_level), .line_out(rx_port_pin));

	initial begin
		clock = 1'h0;
		forever #25 clock = ~clock;
	end
	// Crystal at half the bus rate, phase unrelated
	initial begin
		crystal_ref_clk = 1'h0;
		#13;
		forever #50 crystal_ref_clk = ~crystal_ref_clk;
	end

	task automatic complete_run;
		if (n_mismatch == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; read data and error taken at the ready edge
	task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'h1 && k < 20);
		r = prdata;
		err = pslverr;
		if (k >= 20)
			check(32'h0, 32'h1);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'h0, a, 32'h0);
	endtask
	// Flag clear sequence: status read, then data write
	task automatic send_byte(input logic [7:0] d);
		rd(`OFF_STAT1);
		wr(`OFF_DATA, {24'h0, d});
	endtask
	task automatic seek(input logic lvl);
		int k;
		k = 0;
		while (tx_level !== lvl && k < 4000) begin
			@(negedge clock);
			k++;
		end
	endtask
	task automatic run_len(input logic lvl, output int len);
		seek(lvl);
		len = 0;
		while (tx_level === lvl && len < 4000) begin
			@(negedge clock);
			len++;
		end
	endtask
	task automatic count_falls(input int cyc, output int f);
		logic prev;
		prev = tx_level;
		f = 0;
		repeat (cyc) begin
			@(negedge clock);
			if (prev === 1'h1 && tx_level === 1'h0)
				f++;
			prev = tx_level;
		end
	endtask

	// Hang guard, well beyond the expected run
	initial begin
		repeat (40000) @(posedge clock);
		check(32'h0, 32'h1);
		complete_run();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, rst_n} = '0;
		n_mismatch = 0;
		checks = 0;
		repeat (12) @(posedge clock);
		rst_n <= 1'h1;
		rd(`OFF_STAT1);
		check(r, 32'h1);
		wr(`OFF_STAT1, 32'h0);
		rd(8'h1c);
		check({31'h0, err}, 32'h1);
		rd(`OFF_STAT1);
		check(r, 32'h1);
		// Plain transmit: preamble, framing, empty flag and request
		wr(`OFF_BAUD, 32'h0);
		wr(`OFF_CTRL1, 32'h1);
		wr(`OFF_CTRL2, 32'h5);
		send_byte(8'ha5);
		ptn.get_bits(10, b, w);
		check(32'(w >= 280), 32'h1);
		check(32'(b), 32'({1'h1, 8'ha5, 1'h0}));
		rd(`OFF_STAT1);
		check(r & 32'h1, 32'h1);
		check({31'h0, tx_irq_req}, 32'h1);
		// Nine bits; enable toggled mid-frame queues an idle character
		wr(`OFF_CTRL1, 32'h3);
		wr(`OFF_CTRL3, 32'h1);
		send_byte(8'h3c);
		fork
			ptn.get_bits(11, b, w);
			begin
				seek(1'h0);
				wr(`OFF_CTRL2, 32'h0);
				wr(`OFF_CTRL2, 32'h1);
				send_byte(8'h81);
			end
		join
		check({31'h0, tx_irq_req}, 32'h0);
		check(32'(b), 32'({2'h3, 8'h3c, 1'h0}));
		ptn.get_bits(11, b, w);
		check(32'(b), 32'({2'h3, 8'h81, 1'h0}));
		check(32'(w >= 340), 32'h1);
		// Enable cleared mid-frame: frame ends, pending byte waits
		repeat (40) @(posedge clock);
		wr(`OFF_CTRL1, 32'h1);
		send_byte(8'h0f);
		fork
			ptn.get_bits(10, b, w);
			begin
				seek(1'h0);
				send_byte(8'hf0);
				wr(`OFF_CTRL2, 32'h0);
			end
		join
		check(32'(b), 32'({1'h1, 8'h0f, 1'h0}));
		count_falls(800, n);
		check(n, 32'h0);
		// Unit off mid-frame releases the pin at once
		wr(`OFF_CTRL2, 32'h1);
		seek(1'h0);
		wr(`OFF_CTRL1, 32'h0);
		repeat (3) @(posedge clock);
		check({30'h0, tx_port_pin_oe, tx_level}, 32'h1);
		// Break held for two characters, then a mark before the next start
		wr(`OFF_CTRL1, 32'h1);
		wr(`OFF_CTRL2, 32'h3);
		fork
			run_len(1'h0, n);
			begin
				seek(1'h0);
				repeat (400) @(posedge clock);
				wr(`OFF_CTRL2, 32'h1);
				send_byte(8'h00);
			end
		join
		check(n, 32'd640);
		run_len(1'h1, n);
		check(32'(n >= 32), 32'h1);
		repeat (400) @(posedge clock);
		// Crystal source at half the bus rate doubles the bit time
		wr(`OFF_CTRL1, 32'h9);
		send_byte(8'h00);
		run_len(1'h0, n);
		check(n, 32'd576);
		repeat (320) @(posedge clock);
		// Infrared transmit, every pulse width: start plus three zeros
		wr(`OFF_CTRL1, 32'h5);
		for (int pw = 0; pw < 3; pw++) begin
			wr(`OFF_CTRL2, 32'h1 | (pw << 3));
			send_byte(8'hd5);
			count_falls(700, n);
			check(n, 32'h4);
		end
		// Receive: plain byte, break, then infrared pulses
		wr(`OFF_CTRL1, 32'h1);
		ptn.send_bits({2'h1, 8'ha5, 1'h0}, 10, 1'b0);
		repeat (40) @(posedge clock);
		rd(`OFF_STAT1);
		check(r & 32'h6, 32'h2);
		rd(`OFF_DATA);
		check(r, 32'ha5);
		ptn.send_bits(11'h000, 10, 1'b0);
		repeat (40) @(posedge clock);
		rd(`OFF_STAT1);
		check(r & 32'h6, 32'h6);
		rd(`OFF_STAT2);
		check(r & 32'h1, 32'h1);
		rd(`OFF_CTRL3);
		check(r & 32'h2, 32'h0);
		rd(`OFF_DATA);
		check(r, 32'h0);
		wr(`OFF_CTRL1, 32'h5);
		ptn.send_bits({2'h1, 8'hd5, 1'h0}, 10, 1'b1);
		repeat (40) @(posedge clock);
		rd(`OFF_STAT1);
		check(r & 32'h6, 32'h2);
		rd(`OFF_DATA);
		check(r, 32'hd5);
		complete_run();
	end
endmodule // infrared_uart_tx_codec_test

bind infrared_uart_tx_codec infrared_uart_tx_codec_monitor #(.BIT_CYC(32)) mon (
	.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.crystal_ref_clk(crystal_ref_clk), .rx_port_pin(rx_port_pin),
	.tx_port_pin_o(tx_port_pin_o), .tx_port_pin_oe(tx_port_pin_oe), .tx_irq_req(tx_irq_req)
);
